//--- bench/pet_enc_model.sv
// Incremental encoder model that drives the two lanes into the timer.
`timescale 1ns/10ps
module pet_enc_model (
  input  wire logic pclk,
  output logic      lane_a,
  output logic      lane_b
);
  initial begin
    lane_a = 1'b0;
    lane_b = 1'b0;
  end
  // One full quadrature cycle, with gap cycles between steps to run fast or slow.
  // Forward leads with lane A and reverse with lane B, so each mode sees a clean direction.
  task automatic quad(input logic fwd, input int gap);
    for (int s = 0; s < 4; s++) begin
      repeat (gap) @(posedge pclk);
      if (s[0] ^ fwd) lane_a <= ~lane_a;
      else lane_b <= ~lane_b;
    end
  endtask : quad
endmodule : pet_enc_model

//--- bench/tb_top.sv
// Self-checking bench for the PWM and encoder timer.
`timescale 1ns/10ps
`include "pet_map.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        clk_en = 1'b1;
  logic [2:0]  hold;
  logic        pready, pslverr, enc_lane_a, enc_lane_b;
  logic [2:0]  pwm_out;
  logic [33:0] exp_q[$];
  logic [33:0] ent;
  logic [31:0] seed = 32'h0000_0003;
  logic [6:0]  duty[3];
  logic [15:0] ec;
  int          num_errors = 0;
  int          tests_run = 0;
  int          hi[3];
  int          n, st;
  always #2 pclk = ~pclk;
  pet_enc_model i_enc (.pclk(pclk), .lane_a(enc_lane_a), .lane_b(enc_lane_b));
  pet_timer i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enc_lane_a(enc_lane_a), .enc_lane_b(enc_lane_b),
    .pwm_out(pwm_out));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic chk, input logic err, input logic [31:0] ed);
    @(posedge pclk);
    exp_q.push_back({chk, err, ed});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
    apb(1'b1, a, d, 1'b0, err, 32'h0000_0000);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, 1'b1, 1'b0, e);
  endtask : rdc
  task automatic test_done();
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  // The answer is judged at the edge that completes the transfer.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      ent = exp_q.pop_front();
      `CHK(pslverr, ent[32])
      if (ent[33]) `CHK(prdata, ent[31:0])
    end
  end
  initial begin
    #100000;
    num_errors++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`PET_PERIOD_OFF, 32'h0000_0063);
    rdc(`PET_STATUS_OFF, 32'h0000_0002);
    rdc(`PET_CTRL_OFF, 32'h0000_0000);
    apb(1'b0, 12'h024, 32'h0000_0000, 1'b0, 1'b1, 32'h0000_0000);
    wr(`PET_PERIOD_OFF, 32'h0000_0009, 1'b0);
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 3; c++) begin
        duty[c] = r ? 7'(rnd() % 101) : 7'(c * 50);
        wr(`PET_PWM_CMD_OFF, {17'h0_0000, duty[c], 6'h00, c[1:0] + 2'd1}, 1'b0);
      end
      rdc(`PET_CTRL_OFF, 32'h0000_001C);
      for (int c = 0; c < 3; c++) rdc(12'(`PET_CMP1_OFF + 4 * c), 32'(10 * duty[c] / 100));
      hi = '{0, 0, 0};
      repeat (10) begin
        @(posedge pclk);
        for (int c = 0; c < 3; c++) hi[c] += (pwm_out[c] === 1'b1);
      end
      for (int c = 0; c < 3; c++) `CHK(hi[c], 10 * duty[c] / 100)
      clk_en <= 1'b0; // While the enable is low the outputs must hold.
      repeat (2) @(posedge pclk);
      hold = pwm_out;
      repeat (6) @(posedge pclk) `CHK(pwm_out, hold)
      clk_en <= 1'b1;
    end
    wr(`PET_PWM_CMD_OFF, 32'h0000_0A00, 1'b1);
    wr(`PET_PWM_CMD_OFF, 32'h0000_6501, 1'b1);
    rdc(`PET_CMP1_OFF, 32'(10 * duty[0] / 100));
    rdc(`PET_STATUS_OFF, 32'h0000_0003);
    // Each mode ends back at zero, so a cleared or kept count both start from zero.
    for (int m = 0; m < 3; m++) begin
      wr(`PET_ENC_CMD_OFF, 32'(m), 1'b0);
      st = (m == 2) ? 2 : ((m == 0) ? 1 : -1);
      n = 32'(rnd() % 4) + 1;
      repeat (n) i_enc.quad(1'b1, 32'(rnd() % 16) + 4);
      repeat (6) @(posedge pclk);
      ec = 16'(n * st);
      rdc(`PET_COUNT_OFF, {16'h0000, ec});
      rdc(`PET_STATUS_OFF, {28'h000_0000, m[1:0], m != 1, 1'b0});
      repeat (n) i_enc.quad(1'b0, 4);
      repeat (6) @(posedge pclk);
      rdc(`PET_COUNT_OFF, 32'h0000_0000);
      rdc(`PET_STATUS_OFF, {28'h000_0000, m[1:0], m == 1, 1'b0});
    end
    wr(`PET_ENC_CMD_OFF, 32'h0000_0003, 1'b1);
    rdc(`PET_STATUS_OFF, 32'h0000_0009);
    rdc(`PET_CTRL_OFF, 32'h0000_001E);
    `CHK(pwm_out, 3'b000)
    test_done();
  end
endmodule : tb_top

//--- pkg/pet_map.svh
// Register offsets, field positions, reset values and widths for the PWM and encoder timer.
`ifndef PET_MAP_SVH
`define PET_MAP_SVH
`define PET_CTRL_OFF     12'h000
`define PET_PERIOD_OFF   12'h004
`define PET_CMP1_OFF     12'h008
`define PET_CMP2_OFF     12'h00C
`define PET_CMP3_OFF     12'h010
`define PET_STATUS_OFF   12'h014
`define PET_COUNT_OFF    12'h018
`define PET_PWM_CMD_OFF  12'h01C
`define PET_ENC_CMD_OFF  12'h020
`define PET_CNT_W        16
`define PET_NUM_CH       3
`define PET_DUTY_MAX     7'h64
`define PET_MODE_MAX     2'h2
`define PET_PERIOD_RST   16'h0063
`define PET_CTRL_PWM_EN  0
`define PET_CTRL_ENC_EN  1
`define PET_ST_ERR       0
`define PET_ST_DIR_UP    1
`endif

//--- pkg/pet_pkg.sv
// Types shared by the PWM and encoder timer.
package pet_pkg;
  typedef enum logic [1:0] {PET_ENC_A, PET_ENC_B, PET_ENC_AB} pet_enc_mode_t;
endpackage : pet_pkg

//--- rtl/pet_timer.sv
// PWM and quadrature encoder timer with an APB register slave.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "pet_map.svh"
module pet_timer
  import pet_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        enc_lane_a,
  input  wire logic        enc_lane_b,
  output logic      [2:0]  pwm_out
);
  localparam int W = `PET_CNT_W;

  // Software writes period then a start command holding channel and duty; the compare
  // is derived from the period in hardware so the duty tracks whatever period is set.
  logic [W-1:0]  period_reg, period_next;
  logic [W-1:0]  cnt_reg, cnt_next;
  logic [2:0]    ch_en_reg, ch_en_next;
  logic [6:0]    duty_reg [3], duty_next [3];
  logic [W:0]    cmp_reg [3], cmp_next [3];
  logic          enc_en_reg, enc_en_next;
  pet_enc_mode_t mode_reg, mode_next;
  logic [W-1:0]  enc_cnt_reg, enc_cnt_next;
  logic          dir_up_reg, dir_up_next;
  logic          err_reg, err_next;
  logic [31:0]   prdata_next;
  logic          pslverr_next;
  logic [2:0]    pwm_next;
  logic [1:0]    a_sync_reg, b_sync_reg;
  logic          a_old_reg, b_old_reg;

  // A request is taken only in the wait state before pready rises, so it acts exactly once.
  wire acc = psel && penable && !pready;
  wire wr  = acc && pwrite;
  logic [1:0] ch_idx;
  logic [W+6:0] prod [3];

  always_comb begin
    period_next  = period_reg;
    ch_en_next   = ch_en_reg;
    enc_en_next  = enc_en_reg;
    mode_next    = mode_reg;
    err_next     = err_reg;
    prdata_next  = 32'h0000_0000;
    pslverr_next = 1'b0;
    ch_idx       = 2'd0;
    for (int i = 0; i < 3; i++) begin
      duty_next[i] = duty_reg[i];
    end
    if (wr) begin
      case (paddr)
        `PET_CTRL_OFF: begin
          ch_en_next  = 3'(pwdata[4:2]);
          enc_en_next = pwdata[`PET_CTRL_ENC_EN];
        end
        `PET_PERIOD_OFF: period_next = W'(pwdata);
        `PET_PWM_CMD_OFF: begin
          // Channel in bits 1:0, duty in bits 14:8.
          if (pwdata[1:0] == 2'd0 || pwdata[14:8] > `PET_DUTY_MAX) begin
            err_next     = 1'b1;
            pslverr_next = 1'b1;
          end else begin
            ch_idx             = pwdata[1:0] - 2'd1;
            duty_next[ch_idx]  = pwdata[14:8];
            ch_en_next[ch_idx] = 1'b1;
            err_next           = 1'b0;
          end
        end
        `PET_ENC_CMD_OFF: begin
          if (pwdata[1:0] > `PET_MODE_MAX) begin
            err_next     = 1'b1;
            pslverr_next = 1'b1;
          end else begin
            mode_next   = pet_enc_mode_t'(pwdata[1:0]);
            enc_en_next = 1'b1;
            err_next    = 1'b0;
          end
        end
        default: pslverr_next = 1'b1;
      endcase
    end else if (acc) begin
      case (paddr)
        `PET_CTRL_OFF:    prdata_next = {27'd0, ch_en_reg, enc_en_reg, 1'b0};
        `PET_PERIOD_OFF:  prdata_next = 32'(period_reg);
        `PET_CMP1_OFF:    prdata_next = 32'(cmp_reg[0]);
        `PET_CMP2_OFF:    prdata_next = 32'(cmp_reg[1]);
        `PET_CMP3_OFF:    prdata_next = 32'(cmp_reg[2]);
        `PET_STATUS_OFF:  prdata_next = {28'd0, 2'(mode_reg), dir_up_reg, err_reg};
        `PET_COUNT_OFF:   prdata_next = 32'(enc_cnt_reg);
        `PET_PWM_CMD_OFF: prdata_next = 32'h0000_0000;
        `PET_ENC_CMD_OFF: prdata_next = 32'h0000_0000;
        default:          pslverr_next = 1'b1;
      endcase
    end
  end

  property p_bad_duty;
    @(posedge pclk) disable iff (!presetn)
    clk_en && wr && paddr == `PET_PWM_CMD_OFF && pwdata[14:8] > `PET_DUTY_MAX
    |=> err_reg && pslverr;
  endproperty
  a_bad_duty: assert property (p_bad_duty)
    else $error("Bad duty not rejected.");
  property p_bad_mode;
    @(posedge pclk) disable iff (!presetn)
    clk_en && wr && paddr == `PET_ENC_CMD_OFF && pwdata[1:0] == 2'h3 |=> $stable(mode_reg);
  endproperty
  a_bad_mode: assert property (p_bad_mode)
    else $error("Bad mode changed config.");
  property p_ready;
    @(posedge pclk) disable iff (!presetn)
    clk_en && acc |=> pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("APB answer late.");

  // Shared counter.
  always_comb begin
    cnt_next = (cnt_reg >= period_reg) ? '0 : cnt_reg + 1'b1;
  end

  // Per-channel compare and output. The compare is one bit wider than the counter so that
  // full duty at the largest period still exceeds every count instead of wrapping to zero.
  for (genvar g = 0; g < `PET_NUM_CH; g++) begin : g_ch
    assign prod[g]     = ({7'd0, period_reg} + 1'b1) * {{W{1'b0}}, duty_reg[g]};
    assign cmp_next[g] = (W+1)'(prod[g] / `PET_DUTY_MAX);
    // A compare of 0 never drives high; period+1 always does.
    assign pwm_next[g] = ch_en_reg[g] && !enc_en_reg && ({1'b0, cnt_next} < cmp_reg[g]);
  end

  property p_duty_zero_low;
    @(posedge pclk) disable iff (!presetn)
    clk_en && duty_reg[0] == 7'h00 && cmp_reg[0] == '0 |=> !pwm_out[0];
  endproperty
  a_duty_zero_low: assert property (p_duty_zero_low)
    else $error("Channel 1 high at zero duty.");
  property p_cnt_wrap;
    @(posedge pclk) disable iff (!presetn)
    clk_en && cnt_reg >= period_reg |=> cnt_reg == '0 || !$past(clk_en);
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap)
    else $error("Shared counter failed to wrap.");
  property p_pwm_in_enc;
    @(posedge pclk) disable iff (!presetn)
    clk_en && enc_en_reg |=> pwm_out == 3'b000 || !$past(clk_en);
  endproperty
  a_pwm_in_enc: assert property (p_pwm_in_enc)
    else $error("PWM active in encoder use.");

  // Encoder: edges on the synchronised lanes, direction from the other lane.
  wire a_s = a_sync_reg[1];
  wire b_s = b_sync_reg[1];
  wire a_rise = a_s && !a_old_reg;
  wire b_rise = b_s && !b_old_reg;
  logic step, up;
  always_comb begin
    step = 1'b0;
    up   = dir_up_reg;
    case (mode_reg)
      PET_ENC_A: begin
        step = a_rise;
        up   = !b_s;
      end
      PET_ENC_B: begin
        step = b_rise;
        up   = !a_s;
      end
      PET_ENC_AB: begin
        if (a_rise) begin
          step = 1'b1;
          up   = !b_s;
        end else if (b_rise) begin
          step = 1'b1;
          up   = a_s;
        end
      end
      default: step = 1'b0;
    endcase
    enc_cnt_next = enc_cnt_reg;
    dir_up_next  = dir_up_reg;
    if (enc_en_reg && step) begin
      dir_up_next  = up;
      enc_cnt_next = up ? enc_cnt_reg + 1'b1 : enc_cnt_reg - 1'b1;
    end
  end

  property p_mode0_up;
    @(posedge pclk) disable iff (!presetn)
    clk_en && enc_en_reg && mode_reg == PET_ENC_A && a_rise && !b_s
    |=> enc_cnt_reg == $past(enc_cnt_reg) + 1'b1;
  endproperty
  a_mode0_up: assert property (p_mode0_up)
    else $error("Mode 0 did not count up.");
  property p_mode1_dn;
    @(posedge pclk) disable iff (!presetn)
    clk_en && enc_en_reg && mode_reg == PET_ENC_B && b_rise && a_s
    |=> enc_cnt_reg == $past(enc_cnt_reg) - 1'b1;
  endproperty
  a_mode1_dn: assert property (p_mode1_dn)
    else $error("Mode 1 did not count down.");
  property p_mode2_b;
    @(posedge pclk) disable iff (!presetn)
    clk_en && enc_en_reg && mode_reg == PET_ENC_AB && !a_rise && b_rise |=> dir_up_reg == $past(a_s);
  endproperty
  a_mode2_b: assert property (p_mode2_b)
    else $error("Mode 2 direction wrong.");

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_reg  <= `PET_PERIOD_RST;
      cnt_reg     <= '0;
      ch_en_reg   <= 3'b000;
      enc_en_reg  <= 1'b0;
      mode_reg    <= PET_ENC_A;
      err_reg     <= 1'b0;
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      pwm_out     <= 3'b000;
      enc_cnt_reg <= '0;
      dir_up_reg  <= 1'b1;
      a_sync_reg  <= 2'b00;
      b_sync_reg  <= 2'b00;
      a_old_reg   <= 1'b0;
      b_old_reg   <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        duty_reg[i] <= 7'd0;
        cmp_reg[i]  <= '0;
      end
    end else if (clk_en) begin
      period_reg  <= period_next;
      cnt_reg     <= cnt_next;
      ch_en_reg   <= ch_en_next;
      enc_en_reg  <= enc_en_next;
      mode_reg    <= mode_next;
      err_reg     <= err_next;
      prdata      <= prdata_next;
      pready      <= acc;
      pslverr     <= pslverr_next;
      pwm_out     <= pwm_next;
      enc_cnt_reg <= enc_cnt_next;
      dir_up_reg  <= dir_up_next;
      a_sync_reg  <= {a_sync_reg[0], enc_lane_a};
      b_sync_reg  <= {b_sync_reg[0], enc_lane_b};
      a_old_reg   <= a_s;
      b_old_reg   <= b_s;
      for (int i = 0; i < 3; i++) begin
        duty_reg[i] <= duty_next[i];
        cmp_reg[i]  <= cmp_next[i];
      end
    end
  end

  c_pwm_high: cover property (@(posedge pclk) pwm_out[0]);
  c_enc_step: cover property (@(posedge pclk) enc_en_reg && a_rise);
  c_err: cover property (@(posedge pclk) pslverr);
  c_mode2_b: cover property (@(posedge pclk) enc_en_reg && mode_reg == PET_ENC_AB && b_rise);
endmodule : pet_timer
